// ### design/pmc_pkg.sv
// shared constants for the port mirror, clock output and test mode control
// assumes a 16-bit register port on the same clock as the control logic
package pmc_pkg;

  // register offsets
  localparam logic [15:0] OFS_CONFIG_ONE = 16'h0009;
  localparam logic [15:0] OFS_CONFIG_FOUR = 16'h0031;
  localparam logic [15:0] OFS_MIRROR_ADJUST_TARGET = 16'h00a0;
  localparam logic [15:0] OFS_MIRROR_ADJUST_SOURCE = 16'h00a1;
  localparam logic [15:0] OFS_TEST_MODE_SETUP = 16'h00a8;
  localparam logic [15:0] OFS_AUX_CLOCK_ENABLE = 16'h00c6;
  localparam logic [15:0] OFS_ENERGY_THRESHOLD = 16'h00d0;
  localparam logic [15:0] OFS_ENERGY_LISTEN = 16'h00d1;
  localparam logic [15:0] OFS_BLOCK_STATUS = 16'h00d2;
  localparam logic [15:0] OFS_IO_CONFIGURATION = 16'h0170;

  // reset values
  localparam logic [15:0] RST_CONFIG_ONE = 16'h0000;
  localparam logic [15:0] RST_CONFIG_FOUR = 16'h0000;
  localparam logic [15:0] RST_MIRROR_ADJUST_TARGET = 16'h0000;
  localparam logic [15:0] RST_TEST_MODE_SETUP = 16'h0000;
  localparam logic [15:0] RST_AUX_CLOCK_ENABLE = 16'h0000;
  localparam logic [15:0] RST_ENERGY_THRESHOLD = 16'h2040;
  localparam logic [15:0] RST_ENERGY_LISTEN = 16'h0010;
  localparam logic [15:0] RST_IO_CONFIGURATION = 16'h0000;

  // unlock values that enable test modes and clock output selection
  localparam logic [15:0] TEST_SETUP_KEY = 16'h1002;
  localparam logic [15:0] AUX_CLOCK_KEY = 16'h0010;

  // field positions
  localparam int TEST_MODE_LSB = 13; // config_one [15:13]
  localparam int MIRROR_EN_BIT = 0; // config_four
  localparam int CLK_SRC_LSB = 0; // io_configuration [2:0]
  localparam int CLK_CHAN_LSB = 4; // io_configuration [5:4]
  localparam int CLK_DISABLE_BIT = 6; // io_configuration
  localparam int THR_ON_LSB = 0; // energy threshold [7:0]
  localparam int THR_OFF_LSB = 8; // energy threshold [15:8]
  localparam int ADJ_LO_LSB = 0; // mirror adjust low field [4:0]
  localparam int ADJ_HI_LSB = 8; // mirror adjust high field [12:8]

  // frame limits in bytes
  localparam logic [13:0] STD_FRAME_BYTES = 14'd1518;
  localparam logic [13:0] JUMBO_FRAME_BYTES = 14'd13312;

  // test pattern generator seed and mode-1 step length
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [2:0] MODE1_STEP = 3'h7;

  typedef enum logic [2:0] {
    PMC_TM_NORMAL, PMC_TM_WAVEFORM, PMC_TM_JITTER_MASTER,
    PMC_TM_JITTER_SLAVE, PMC_TM_DISTORTION
  } pmc_test_mode_e;

  typedef enum logic [2:0] {
    PMC_CK_REFERENCE, PMC_CK_RX_125, PMC_CK_RX_25, PMC_CK_TX_LINE
  } pmc_clk_src_e;

  typedef enum logic [1:0] {
    PMC_SPD_10, PMC_SPD_100, PMC_SPD_1000
  } pmc_speed_e;

endpackage

// ### design/pmc_energy_detect.sv
// iir based energy detector with hysteresis and listening periods
// assumes magnitude samples on ref_clk from the receive front end
`timescale 1ns/100ps
module pmc_energy_detect (
  input wire logic ref_clk, // control clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [7:0] sample, // received signal magnitude
  input wire logic [7:0] thr_on, // level to declare energy
  input wire logic [7:0] thr_off, // level to drop energy
  input wire logic [15:0] listen, // cycles a crossing must persist
  output logic detect, // energy present
  output logic [7:0] level // filtered level
);
  import pmc_pkg::*;

  typedef struct packed {
    logic [11:0] acc;
    logic [15:0] cnt;
    logic det;
  } pmc_ed_s;

  pmc_ed_s s;
  pmc_ed_s next_s;
  logic signed [12:0] diff;
  logic [15:0] need;

  // one-pole filter, step 1/8; then hysteresis with a persistence count
  always_comb begin
    next_s = s;
    diff = $signed({1'b0, sample, 4'h0}) - $signed({1'b0, s.acc});
    next_s.acc = s.acc + 12'(diff >>> 3); // RULE1
    need = (listen == 16'h0000) ? 16'h0001 : listen;
    // crossing must hold for the whole listening period, which stops chatter
    if (!s.det ? (s.acc[11:4] >= thr_on) : (s.acc[11:4] <= thr_off)) begin
      if (s.cnt + 16'h0001 >= need) begin
        next_s.det = !s.det; // RULE1
        next_s.cnt = 16'h0000;
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
      end
    end else begin
      next_s.cnt = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign detect = s.det;
  assign level = s.acc[11:4];
endmodule

// ### design/pmc_phy_port_mirror_clkout_ctrl.sv
// mirror, clock output select, test mode and frame limit control of the phy
// assumes core-side pair signals on ref_clk; media receive pins are asynchronous
`timescale 1ns/100ps
// Function
// RULE1: energy detect via iir, thresholds, hysteresis
// RULE2: four transmit test modes plus normal
// RULE3: host writes setup key before test modes
// RULE4: test patterns on pairs, tx clock out
// RULE5: 13 KB frames at 1000 and 100
// RULE6: io register picks clock output source
// RULE7: host writes aux key for selection
// RULE8: reference clock output after reset
// RULE9: receive clock at 125 or 25 MHz
// RULE10: tx clock; gigabit picks any channel
// RULE11: disable bit stops clock output toggling
// RULE12: receive clock locked to partner transmit
// RULE13: host avoids pin reset of primary
// RULE14: mirroring by strap or config bit
// RULE15: mirroring also inverts pair polarity
// RULE16: gigabit mirror maps A-D, B-C swapped
// RULE17: 10/100 mirror moves A,B to D,C
// RULE18: host swaps adjust fields when mirroring
// RULE19: same remap on transmit and receive
module pmc_phy_port_mirror_clkout_ctrl (
  input wire logic ref_clk, // 100 MHz control clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [15:0] reg_addr, // register address
  input wire logic [15:0] reg_wdata, // write data
  output logic [15:0] reg_rdata, // read data, one cycle after reg_rd
  output logic reg_rvalid, // read data valid pulse
  input wire logic mirror_strap, // mirror strap pin
  input wire logic [1:0] link_speed, // pmc_pkg::pmc_speed_e from core
  input wire logic [3:0] core_tx_p, // core transmit, positive leg per channel
  input wire logic [3:0] core_tx_n, // core transmit, negative leg per channel
  output logic [3:0] channel_positive, // media pair positive legs, a..d
  output logic [3:0] channel_negative, // media pair negative legs, a..d
  input wire logic [3:0] media_rx_p, // media receive positive legs
  input wire logic [3:0] media_rx_n, // media receive negative legs
  output logic [3:0] core_rx_p, // receive positive to core, remapped
  output logic [3:0] core_rx_n, // receive negative to core, remapped
  input wire logic rx_clk_locked, // recovery loop locked to partner
  input wire logic [7:0] energy_sample, // receive magnitude sample
  output logic energy_detect, // signal energy present
  input wire logic [15:0] adjust_source, // live value behind source register
  output logic [15:0] adjust_target, // target register to the dsp
  output logic [2:0] clkout_src, // pmc_pkg::pmc_clk_src_e to clock mux
  output logic [1:0] clkout_chan, // channel for rx/tx clock sources
  output logic clkout_run, // clock output toggles when high
  output logic test_active, // a transmit test mode is running
  output logic [13:0] max_frame_bytes // longest frame accepted
);
  import pmc_pkg::*;

  typedef enum logic [3:0] {
    PMC_R_NONE, PMC_R_CONFIG_ONE, PMC_R_CONFIG_FOUR, PMC_R_ADJ_TGT, PMC_R_ADJ_SRC,
    PMC_R_TM_SETUP, PMC_R_AUX, PMC_R_ED_THR, PMC_R_ED_LISTEN,
    PMC_R_STATUS, PMC_R_IOCFG
  } pmc_reg_e;

  typedef struct packed {
    logic [15:0] config_one;
    logic [15:0] config_four;
    logic [15:0] adj_tgt;
    logic [15:0] tm_setup;
    logic [15:0] aux;
    logic [15:0] ed_thr;
    logic [15:0] ed_listen;
    logic [15:0] iocfg;
    logic strap_s1;
    logic strap_s2;
    logic strap_taken;
    logic strap_mirror;
    logic [3:0] rxp_s1;
    logic [3:0] rxn_s1;
    logic [3:0] rxp_s2;
    logic [3:0] rxn_s2;
    logic lock_s1;
    logic lock_s2;
    logic [3:0] tx_p;
    logic [3:0] tx_n;
    logic [3:0] rx_p;
    logic [3:0] rx_n;
    logic [15:0] rdata;
    logic rvalid;
    logic [15:0] lfsr;
    logic [2:0] step;
    logic tpat;
    logic [2:0] ck_src;
    logic [1:0] ck_chan;
    logic ck_run;
    logic [13:0] max_frame;
  } pmc_state_s;

  pmc_state_s s;
  pmc_state_s next_s;
  logic ed_det;
  logic [7:0] ed_level;
  logic mirror_on;
  pmc_test_mode_e tmode;
  logic tm_on;
  logic [15:0] status;
  pmc_reg_e wsel;
  pmc_reg_e rsel;

  // address decode shared by the write and read paths
  function automatic pmc_reg_e reg_decode(input logic [15:0] addr);
    unique case (addr)
      OFS_CONFIG_ONE: reg_decode = PMC_R_CONFIG_ONE;
      OFS_CONFIG_FOUR: reg_decode = PMC_R_CONFIG_FOUR;
      OFS_MIRROR_ADJUST_TARGET: reg_decode = PMC_R_ADJ_TGT;
      OFS_MIRROR_ADJUST_SOURCE: reg_decode = PMC_R_ADJ_SRC;
      OFS_TEST_MODE_SETUP: reg_decode = PMC_R_TM_SETUP;
      OFS_AUX_CLOCK_ENABLE: reg_decode = PMC_R_AUX;
      OFS_ENERGY_THRESHOLD: reg_decode = PMC_R_ED_THR;
      OFS_ENERGY_LISTEN: reg_decode = PMC_R_ED_LISTEN;
      OFS_BLOCK_STATUS: reg_decode = PMC_R_STATUS;
      OFS_IO_CONFIGURATION: reg_decode = PMC_R_IOCFG;
      default: reg_decode = PMC_R_NONE;
    endcase
  endfunction

  // mirror swaps a<->d and b<->c; it is its own inverse so both paths share it
  function automatic logic [3:0] pair_map(input logic [3:0] v, input logic mir);
    pair_map = mir ? {v[0], v[1], v[2], v[3]} : v; // RULE16 RULE17
  endfunction

  pmc_energy_detect u_energy (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sample(energy_sample),
    .thr_on(s.ed_thr[THR_ON_LSB +: 8]),
    .thr_off(s.ed_thr[THR_OFF_LSB +: 8]),
    .listen(s.ed_listen),
    .detect(ed_det),
    .level(ed_level)
  );

  // decoded modes
  always_comb begin
    wsel = reg_decode(reg_addr);
    rsel = reg_decode(reg_addr);
    mirror_on = s.strap_mirror | s.config_four[MIRROR_EN_BIT]; // RULE14
    tmode = pmc_test_mode_e'(s.config_one[TEST_MODE_LSB +: 3]); // RULE2
    // test modes only run once the setup key is in place
    tm_on = (tmode != PMC_TM_NORMAL) && (tmode <= PMC_TM_DISTORTION)
      && (s.tm_setup == TEST_SETUP_KEY); // RULE3
    status = {8'h00, ed_level[7:4], s.lock_s2, mirror_on, tm_on, ed_det};
  end

  always_comb begin
    next_s = s;

    // strap passes two flops, then is caught once after reset release
    next_s.strap_s1 = mirror_strap;
    next_s.strap_s2 = s.strap_s1;
    if (!s.strap_taken) begin
      next_s.strap_taken = 1'b1;
      next_s.strap_mirror = s.strap_s2; // RULE14
    end

    // asynchronous media and lock inputs
    next_s.rxp_s1 = media_rx_p;
    next_s.rxn_s1 = media_rx_n;
    next_s.rxp_s2 = s.rxp_s1;
    next_s.rxn_s2 = s.rxn_s1;
    next_s.lock_s1 = rx_clk_locked;
    next_s.lock_s2 = s.lock_s1;

    // register writes; source and status are read-only
    if (reg_wr) begin
      unique case (wsel)
        PMC_R_CONFIG_ONE: next_s.config_one = reg_wdata; // RULE2
        PMC_R_CONFIG_FOUR: next_s.config_four = reg_wdata;
        PMC_R_ADJ_TGT: next_s.adj_tgt = reg_wdata;
        PMC_R_TM_SETUP: next_s.tm_setup = reg_wdata;
        PMC_R_AUX: next_s.aux = reg_wdata;
        PMC_R_ED_THR: next_s.ed_thr = reg_wdata; // RULE1
        PMC_R_ED_LISTEN: next_s.ed_listen = reg_wdata;
        PMC_R_IOCFG: next_s.iocfg = reg_wdata; // RULE6
        PMC_R_NONE, PMC_R_ADJ_SRC, PMC_R_STATUS: begin
        end
      endcase
    end

    // read answer one cycle later; unmapped addresses read zero
    next_s.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (rsel)
        PMC_R_CONFIG_ONE: next_s.rdata = s.config_one;
        PMC_R_CONFIG_FOUR: next_s.rdata = s.config_four;
        PMC_R_ADJ_TGT: next_s.rdata = s.adj_tgt;
        PMC_R_ADJ_SRC: next_s.rdata = adjust_source; // RULE18
        PMC_R_TM_SETUP: next_s.rdata = s.tm_setup;
        PMC_R_AUX: next_s.rdata = s.aux;
        PMC_R_ED_THR: next_s.rdata = s.ed_thr;
        PMC_R_ED_LISTEN: next_s.rdata = s.ed_listen;
        PMC_R_STATUS: next_s.rdata = status;
        PMC_R_IOCFG: next_s.rdata = s.iocfg;
        PMC_R_NONE: next_s.rdata = 16'h0000;
      endcase
    end

    // test pattern source: stepped square for mode 1, fast toggle for the
    // jitter modes, pseudo-random symbols for distortion
    next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
    next_s.step = s.step + 3'h1;
    unique case (tmode)
      PMC_TM_WAVEFORM: begin
        if (s.step == MODE1_STEP) begin
          next_s.tpat = !s.tpat;
        end
      end
      PMC_TM_JITTER_MASTER, PMC_TM_JITTER_SLAVE: next_s.tpat = !s.tpat;
      PMC_TM_DISTORTION: next_s.tpat = s.lfsr[15];
      default: next_s.tpat = 1'b0;
    endcase

    // transmit drive: test pattern replaces core data on every pair
    if (tm_on) begin
      next_s.tx_p = pair_map({4{s.tpat}}, 1'b0) ^ {4{mirror_on}}; // RULE4 RULE15
      next_s.tx_n = ~next_s.tx_p;
    end else if (mirror_on) begin
      // polarity inversion is a leg swap after the channel remap
      next_s.tx_p = pair_map(core_tx_n, 1'b1); // RULE15 RULE19
      next_s.tx_n = pair_map(core_tx_p, 1'b1); // RULE15 RULE19
    end else begin
      next_s.tx_p = core_tx_p;
      next_s.tx_n = core_tx_n;
    end

    // receive sampling gets the identical remap and inversion
    if (mirror_on) begin
      next_s.rx_p = pair_map(s.rxn_s2, 1'b1); // RULE15 RULE19
      next_s.rx_n = pair_map(s.rxp_s2, 1'b1); // RULE15 RULE19
    end else begin
      next_s.rx_p = s.rxp_s2;
      next_s.rx_n = s.rxn_s2;
    end

    // clock output source; selection is honoured only after the aux key
    next_s.ck_src = PMC_CK_REFERENCE; // RULE8
    next_s.ck_chan = 2'h0;
    if (tm_on) begin
      next_s.ck_src = PMC_CK_TX_LINE; // RULE4
    end else if (s.aux == AUX_CLOCK_KEY) begin // RULE7
      unique case (pmc_clk_src_e'(s.iocfg[CLK_SRC_LSB +: 3]))
        PMC_CK_RX_125, PMC_CK_RX_25: begin
          // recovered clock is useless until locked, so hold reference
          if (s.lock_s2) begin // RULE12
            next_s.ck_src = s.iocfg[CLK_SRC_LSB +: 3]; // RULE6 RULE9
          end
        end
        PMC_CK_TX_LINE: next_s.ck_src = PMC_CK_TX_LINE; // RULE10
        default: next_s.ck_src = PMC_CK_REFERENCE;
      endcase
    end
    // channel choice only means something at gigabit
    if (pmc_speed_e'(link_speed) == PMC_SPD_1000) begin
      next_s.ck_chan = s.iocfg[CLK_CHAN_LSB +: 2]; // RULE10
    end
    next_s.ck_run = !s.iocfg[CLK_DISABLE_BIT]; // RULE11

    // frame limit follows speed
    unique case (pmc_speed_e'(link_speed))
      PMC_SPD_1000, PMC_SPD_100: next_s.max_frame = JUMBO_FRAME_BYTES; // RULE5
      default: next_s.max_frame = STD_FRAME_BYTES;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
      // strap sync keeps sampling in reset so the capture at release is primed
      s.strap_s1 <= mirror_strap; // RULE14
      s.strap_s2 <= s.strap_s1; // RULE14
      s.config_one <= RST_CONFIG_ONE;
      s.config_four <= RST_CONFIG_FOUR;
      s.adj_tgt <= RST_MIRROR_ADJUST_TARGET;
      s.tm_setup <= RST_TEST_MODE_SETUP;
      s.aux <= RST_AUX_CLOCK_ENABLE;
      s.ed_thr <= RST_ENERGY_THRESHOLD;
      s.ed_listen <= RST_ENERGY_LISTEN;
      s.iocfg <= RST_IO_CONFIGURATION;
      s.lfsr <= LFSR_SEED;
      s.ck_src <= PMC_CK_REFERENCE; // RULE8
      s.ck_run <= 1'b1; // RULE8
      s.max_frame <= STD_FRAME_BYTES;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state; test_active is decoded from config_one and tm_setup
  assign reg_rdata = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign channel_positive = s.tx_p;
  assign channel_negative = s.tx_n;
  assign core_rx_p = s.rx_p;
  assign core_rx_n = s.rx_n;
  assign energy_detect = ed_det;
  assign adjust_target = s.adj_tgt;
  assign clkout_src = s.ck_src;
  assign clkout_chan = s.ck_chan;
  assign clkout_run = s.ck_run;
  assign test_active = tm_on;
  assign max_frame_bytes = s.max_frame;
endmodule

// ### bench/pmc_ctrl_checker.sv
// checker for mirror maps, clock output choice, test mode and frame limit
// assumes it is bound onto the control top and sees only its ports
`timescale 1ns/100ps
module pmc_ctrl_checker (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset, low
  input wire logic [1:0] link_speed, // speed code
  input wire logic [13:0] max_frame_bytes, // frame limit
  input wire logic [3:0] core_tx_p, // tx in
  input wire logic [3:0] core_tx_n, // tx in
  input wire logic [3:0] channel_positive, // tx out
  input wire logic [3:0] channel_negative, // tx out
  input wire logic [3:0] media_rx_p, // rx pins
  input wire logic [3:0] media_rx_n, // rx pins
  input wire logic [3:0] core_rx_p, // rx out
  input wire logic [3:0] core_rx_n, // rx out
  input wire logic rx_clk_locked, // lock pin
  input wire logic [2:0] clkout_src, // clock source
  input wire logic clkout_run, // clock running
  input wire logic test_active // test mode on
);
  import pmc_pkg::*;
  typedef struct packed {
    logic [2:0] up;
  } pmc_chk_s;
  pmc_chk_s st;
  pmc_chk_s next_st;
  // cycles since reset, so deep history never reaches into reset
  always_comb begin
    next_st = st;
    if (st.up != 3'h7)
      next_st.up = st.up + 3'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end
  function automatic logic [3:0] rv(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction
  // straight, or mirrored with both legs swapped; strap state is not visible here
  function automatic logic ok4(input logic [3:0] gp, gn, p, n);
    return (gp == p && gn == n) || (gp == rv(n) && gn == rv(p));
  endfunction
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  AST_FRAME_JUMBO: assert property (
    link_speed inside {2'h1, 2'h2} |=> max_frame_bytes == JUMBO_FRAME_BYTES)
    else $error("jumbo limit missing at 100 or 1000");
  AST_FRAME_STD: assert property (
    link_speed == 2'h0 |=> max_frame_bytes == STD_FRAME_BYTES)
    else $error("frame limit wrong at 10");
  AST_TX_MAP: assert property (
    !test_active |=> ok4(channel_positive, channel_negative, $past(core_tx_p), $past(core_tx_n)))
    else $error("transmit pairs neither straight nor mirrored");
  AST_RX_MAP: assert property (
    st.up >= 3'h4 |-> ok4(core_rx_p, core_rx_n, $past(media_rx_p, 2), $past(media_rx_n, 2))
      || ok4(core_rx_p, core_rx_n, $past(media_rx_p, 3), $past(media_rx_n, 3)))
    else $error("receive pairs neither straight nor mirrored");
  AST_RESET_CLK: assert property (
    $rose(rst_n) |-> clkout_src == 3'h0 && clkout_run)
    else $error("clock output not reference after reset");
  AST_TEST_SRC: assert property (
    test_active |=> clkout_src == 3'h3)
    else $error("test mode without transmit clock out");
  AST_TEST_PAIRS: assert property (
    test_active |=> channel_negative == ~channel_positive)
    else $error("test pattern legs not complementary");
  AST_LOCK_FALLBACK: assert property (
    st.up >= 3'h4 && clkout_src inside {3'h1, 3'h2} |-> $past(rx_clk_locked, 2)
      || $past(rx_clk_locked, 3))
    else $error("receive clock out while unlocked");
  AST_SRC_RANGE: assert property (
    clkout_src <= 3'h3)
    else $error("clock source code out of range");
  cover property (test_active);
  cover property (clkout_src == 3'h2);
  cover property (!clkout_run);
  cover property (channel_negative == 4'h8);
endmodule
bind pmc_phy_port_mirror_clkout_ctrl pmc_ctrl_checker u_pmc_ctrl_checker (
  .ref_clk(ref_clk), .rst_n(rst_n), .link_speed(link_speed),
  .max_frame_bytes(max_frame_bytes), .core_tx_p(core_tx_p), .core_tx_n(core_tx_n),
  .channel_positive(channel_positive), .channel_negative(channel_negative),
  .media_rx_p(media_rx_p), .media_rx_n(media_rx_n), .core_rx_p(core_rx_p),
  .core_rx_n(core_rx_n), .rx_clk_locked(rx_clk_locked), .clkout_src(clkout_src),
  .clkout_run(clkout_run), .test_active(test_active)
);

// ### bench/pmc_media_partner.sv
// link partner and media model as seen from the receive pins
// assumes the bench sets the pattern, lock and energy wishes
`timescale 1ns/100ps
module pmc_media_partner (
  input wire logic [3:0] pattern, // bit sent on each channel
  input wire logic lock_on, // partner clock steady
  input wire logic energy_on, // partner sending
  output logic [3:0] rx_p, // positive legs
  output logic [3:0] rx_n, // negative legs
  output logic locked, // recovered clock lock
  output logic [7:0] sample // magnitude on the wire
);
  // legs always complementary; lock needs a partner that sends
  assign rx_p = pattern;
  assign rx_n = ~pattern;
  assign locked = lock_on & energy_on;
  assign sample = energy_on ? 8'hf0 : 8'h00;
endmodule

// ### bench/test_phy_port_mirror_clkout_ctrl.sv
// self-checking bench for mirror, clock output, test mode, frames, energy
// assumes the checker binds itself onto the control top
`timescale 1ns/100ps
module test_phy_port_mirror_clkout_ctrl;
  import pmc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [1:0] link_speed = 2'h2;
  logic [3:0] core_tx_p = 4'h0;
  logic [3:0] core_tx_n = 4'hf;
  logic [3:0] pattern = 4'h0;
  logic lock_on = 1'b0;
  logic energy_on = 1'b0;
  logic mirror_strap = 1'b0;
  logic [15:0] adjust_source = 16'h1a05;
  logic [15:0] reg_rdata, adjust_target;
  logic reg_rvalid, energy_detect, clkout_run, test_active, rx_clk_locked;
  logic [3:0] channel_positive, channel_negative, media_rx_p, media_rx_n, core_rx_p, core_rx_n;
  logic [2:0] clkout_src;
  logic [1:0] clkout_chan;
  logic [13:0] max_frame_bytes;
  logic [7:0] energy_sample;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  pmc_phy_port_mirror_clkout_ctrl u_pmc_phy_port_mirror_clkout_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .mirror_strap(mirror_strap), .link_speed(link_speed),
    .core_tx_p(core_tx_p), .core_tx_n(core_tx_n), .channel_positive(channel_positive),
    .channel_negative(channel_negative), .media_rx_p(media_rx_p), .media_rx_n(media_rx_n),
    .core_rx_p(core_rx_p), .core_rx_n(core_rx_n), .rx_clk_locked(rx_clk_locked),
    .energy_sample(energy_sample), .energy_detect(energy_detect),
    .adjust_source(adjust_source), .adjust_target(adjust_target), .clkout_src(clkout_src),
    .clkout_chan(clkout_chan), .clkout_run(clkout_run), .test_active(test_active),
    .max_frame_bytes(max_frame_bytes)
  );
  pmc_media_partner u_pmc_media_partner (
    .pattern(pattern), .lock_on(lock_on), .energy_on(energy_on), .rx_p(media_rx_p),
    .rx_n(media_rx_n), .locked(rx_clk_locked), .sample(energy_sample)
  );
  // 100 MHz clock
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic final_report;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      final_report;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, idle cycle between requests
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk({15'h0, reg_rvalid}, 16'h0001);
    chk(reg_rdata, exp);
  endtask
  // enough for register, sync flops and output register to land
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic t_regs;
    rd(OFS_CONFIG_ONE, RST_CONFIG_ONE);
    rd(OFS_IO_CONFIGURATION, RST_IO_CONFIGURATION);
    rd(OFS_AUX_CLOCK_ENABLE, RST_AUX_CLOCK_ENABLE);
    rd(OFS_ENERGY_THRESHOLD, RST_ENERGY_THRESHOLD);
    rd(16'h0055, 16'h0000);
    wr(OFS_MIRROR_ADJUST_SOURCE, 16'hffff);
    rd(OFS_MIRROR_ADJUST_SOURCE, adjust_source);
    wr(OFS_MIRROR_ADJUST_TARGET, {3'h0, adjust_source[4:0], 3'h0, adjust_source[12:8]});
    settle;
    chk(adjust_target, 16'h051a);
    rd(OFS_MIRROR_ADJUST_TARGET, 16'h051a);
  endtask
  // both directions, mirror off then on, at every speed
  task automatic t_mirror;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk);
      link_speed <= s[1:0];
      core_tx_p <= 4'h1;
      core_tx_n <= 4'he;
      pattern <= 4'h1;
      wr(OFS_CONFIG_FOUR, 16'h0000);
      settle;
      chk({8'h0, channel_positive, channel_negative}, 16'h001e);
      chk({8'h0, core_rx_p, core_rx_n}, 16'h001e);
      wr(OFS_CONFIG_FOUR, 16'h0001);
      settle;
      chk({8'h0, channel_positive, channel_negative}, 16'h0078);
      chk({8'h0, core_rx_p, core_rx_n}, 16'h0078);
      rd(OFS_CONFIG_FOUR, 16'h0001);
    end
  endtask
  task automatic t_frames;
    for (int s = 0; s < 3; s++) begin
      @(posedge ref_clk);
      link_speed <= s[1:0];
      settle;
      chk({2'h0, max_frame_bytes}, {2'h0, s == 0 ? STD_FRAME_BYTES : JUMBO_FRAME_BYTES});
    end
  endtask
  task automatic t_clock;
    // transmit source needs no lock, so only the missing key can hold reference
    wr(OFS_IO_CONFIGURATION, 16'h0003);
    settle;
    chk({13'h0, clkout_src}, 16'h0000);
    wr(OFS_AUX_CLOCK_ENABLE, AUX_CLOCK_KEY);
    @(posedge ref_clk);
    lock_on <= 1'b1;
    energy_on <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(OFS_IO_CONFIGURATION, {10'h0, s[1:0], 1'b0, s[2:0]});
      settle;
      chk({11'h0, clkout_chan, clkout_src}, {11'h0, s[1:0], s[2:0]});
    end
    @(posedge ref_clk);
    lock_on <= 1'b0;
    energy_on <= 1'b0;
    wr(OFS_IO_CONFIGURATION, 16'h0001);
    settle;
    chk({13'h0, clkout_src}, 16'h0000);
    wr(OFS_IO_CONFIGURATION, 16'h0040);
    settle;
    chk({15'h0, clkout_run}, 16'h0000);
    wr(OFS_IO_CONFIGURATION, 16'h0000);
    settle;
    chk({15'h0, clkout_run}, 16'h0001);
  endtask
  // mode 2 stays off without the key; behind the key modes 1..4 run and 5 falls back to normal
  task automatic t_test;
    wr(OFS_CONFIG_ONE, 16'h4000);
    settle;
    chk({15'h0, test_active}, 16'h0000);
    wr(OFS_TEST_MODE_SETUP, TEST_SETUP_KEY);
    for (int m = 1; m < 6; m++) begin
      wr(OFS_CONFIG_ONE, {m[2:0], 13'h0});
      settle;
      chk({15'h0, test_active}, {15'h0, m < 5});
      chk({13'h0, clkout_src}, m < 5 ? 16'h0003 : 16'h0000);
    end
    wr(OFS_CONFIG_ONE, 16'h0000);
  endtask
  // detect must keep its old value for three cycles, then follow within a bound
  task automatic t_energy(input logic on);
    int k;
    @(posedge ref_clk);
    energy_on <= on;
    repeat (3) @(negedge ref_clk);
    chk({15'h0, energy_detect}, {15'h0, !on});
    k = 0;
    while (energy_detect !== on && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    chk({15'h0, energy_detect}, {15'h0, on});
  endtask
  // strap alone must mirror after a pin reset; config_four is back at zero
  task automatic t_strap;
    @(posedge ref_clk);
    mirror_strap <= 1'b1;
    // nothing hangs on the clock output here, so a pin reset is harmless
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    settle;
    chk({8'h0, channel_positive, channel_negative}, 16'h0078);
    rd(OFS_CONFIG_FOUR, RST_CONFIG_FOUR);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk({12'h0, clkout_run, clkout_src}, 16'h0008);
    t_regs;
    t_mirror;
    t_frames;
    t_clock;
    t_test;
    t_energy(1'b1);
    t_energy(1'b0);
    t_strap;
    final_report;
  end
endmodule
